// ===== rtl/lrm_pkg.sv
/*
 * Constants for the link reliability monitor: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 40 MHz core clock and a 32-bit register port.
 */
// Notes on behaviour
// - Error tally is 8 bits in counter bits 7:0, saturating, one step per error.
// - Tally clears on link retrain request or link down (Detect).
// - Rising enable clears both tally and window count.
// - Once link judged unreliable, both counters freeze unless a clear applies.
// - Tally restarts from zero when window count equals programmed period.
// - Counters keep running while the monitor is disabled.
// - Window count is 24 bits in counter bits 31:8, microsecond steps, saturating.
// - Window count clears on link retrain request or full retrain through Detect.
// - Window count restarts from zero when it equals the programmed period.
// - Sticky write-one-clear unreliable flag sets when tally reaches threshold while enabled.
// - Threshold resets to 0xff, period to 0xffffff; software avoids zero.
// - Error type select: 0 counts bit errors, 1 counts link-state errors.
// - Enable bit defaults to zero and gates the decision and flagging.
package lrm_pkg;
  // ==========================================================
  // Register map
  localparam logic [11:0] ctrl_off = 12'h560;
  localparam logic [11:0] stat_off = 12'h564;
  localparam logic [11:0] thr_off = 12'h568;
  localparam logic [11:0] cnt_off = 12'h56c;
  localparam logic [11:0] irq_mask_off = 12'h570;
  localparam logic [11:0] irq_stat_off = 12'h574;
  // ==========================================================
  // Fields
  localparam int en_bit = 0;
  localparam int type_bit = 1;
  localparam int flag_bit = 0;
  localparam int tally_w = 8;
  localparam int window_w = 24;
  localparam int window_lsb = 8;
  // ==========================================================
  // Reset values
  localparam logic [7:0] thr_rst = 8'hff;
  localparam logic [23:0] period_rst = 24'hffffff;
  // ==========================================================
  // Timing
  localparam int clk_mhz = 40;
  localparam int tick_ns = 1000;
  localparam int clk_ns = 25;
  localparam int tick_cycles = tick_ns / clk_ns;
endpackage : lrm_pkg

// ===== rtl/lrm_tick.sv
/*
 * Microsecond tick prescaler.
 * Assumes the core clock rate given in lrm_pkg.
 */
`timescale 1ns/100ps
module lrm_tick (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Tick out
  output logic tick
);
  logic [7:0] div_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      div_q <= 8'h00;
    end else if (div_q == 8'(lrm_pkg::tick_cycles - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign tick = (div_q == 8'(lrm_pkg::tick_cycles - 1));
endmodule : lrm_tick

// ===== rtl/lrm_sat_cnt.sv
/*
 * Saturating counter with clear, freeze and restart inputs.
 * Clear beats freeze beats restart beats counting.
 */
`timescale 1ns/100ps
module lrm_sat_cnt #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control
  input wire logic clr,
  input wire logic freeze,
  input wire logic restart,
  input wire logic inc,
  // Count
  output logic [W-1:0] count
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (clr) begin
      cnt_q <= '0;
    end else if (freeze) begin
      cnt_q <= cnt_q;
    end else if (restart) begin
      cnt_q <= '0;
    end else if (inc && cnt_q != '1) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign count = cnt_q;
endmodule : lrm_sat_cnt

// ===== rtl/link_error_rate_monitor_counters.sv
/*
 * Link reliability monitor: error tally and window counters, controls,
 * sticky unreliable flag, interrupt, and register port.
 * Assumes error and link-state inputs are single-cycle synchronous pulses
 * or levels from the link training and error logic.
 */
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module link_error_rate_monitor_counters (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Link events
  input wire logic link_retrain_request,
  input wire logic ltssm_in_detect,
  input wire logic lcrc_error,
  input wire logic l0_to_recovery_local,
  // Status out
  output logic unreliable_link_flag,
  output logic irq
);
  // ==========================================================
  // Control registers
  logic en_q;
  logic type_q;
  logic en_prev_q;
  logic [7:0] thr_q;
  logic [23:0] period_q;
  logic flag_q;
  logic irq_mask_q;
  logic irq_stat_q;
  logic [31:0] rdata_q;
  logic tick;
  logic [7:0] error_tally;
  logic [23:0] window_elapsed_count;
  logic clr_all;
  logic clr_link;
  logic period_hit;
  logic err_evt;
  logic flag_set;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      en_q <= 1'b0;
      type_q <= 1'b0;
      thr_q <= lrm_pkg::thr_rst;
      period_q <= lrm_pkg::period_rst;
      irq_mask_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == lrm_pkg::ctrl_off) begin
        en_q <= reg_wdata[lrm_pkg::en_bit];
        type_q <= reg_wdata[lrm_pkg::type_bit];
      end
      if (reg_addr == lrm_pkg::thr_off) begin
        thr_q <= reg_wdata[lrm_pkg::tally_w-1:0];
        period_q <= reg_wdata[31:lrm_pkg::window_lsb];
      end
      if (reg_addr == lrm_pkg::irq_mask_off) begin
        irq_mask_q <= reg_wdata[lrm_pkg::flag_bit];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_q;
    end
  end

  // ==========================================================
  // Counter conditions
  // Retrain or link-down clears both; enable rising clears both.
  assign clr_link = link_retrain_request | ltssm_in_detect;
  assign clr_all = clr_link | (en_q & ~en_prev_q);
  assign period_hit = (window_elapsed_count == period_q);
  assign err_evt = type_q ? l0_to_recovery_local : lcrc_error;

  // Freeze acts on the flag only; counters ignore the enable itself.
  lrm_tick u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tick(tick)
  );

  lrm_sat_cnt #(.W(lrm_pkg::tally_w)) u_tally (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clr(clr_all),
    .freeze(flag_q),
    .restart(period_hit),
    .inc(err_evt),
    .count(error_tally)
  );

  lrm_sat_cnt #(.W(lrm_pkg::window_w)) u_window (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clr(clr_all),
    .freeze(flag_q),
    .restart(period_hit),
    .inc(tick),
    .count(window_elapsed_count)
  );

  // ==========================================================
  // Unreliable flag and interrupt
  // Judgement waits one cycle after enable rises, so a tally gathered
  // while disabled cannot raise a false flag in the clearing cycle.
  assign flag_set = en_q & en_prev_q & (error_tally >= thr_q);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else if (flag_set) begin
      flag_q <= 1'b1;
    end else if (reg_wr && reg_addr == lrm_pkg::stat_off && reg_wdata[lrm_pkg::flag_bit]) begin
      flag_q <= 1'b0;
    end
  end

  // Set wins over read-clear so a coincident event is kept.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_stat_q <= 1'b0;
    end else if (flag_set && !flag_q) begin
      irq_stat_q <= 1'b1;
    end else if (reg_rd && reg_addr == lrm_pkg::irq_stat_off) begin
      irq_stat_q <= 1'b0;
    end
  end

  assign irq = irq_stat_q & irq_mask_q;
  assign unreliable_link_flag = flag_q;

  // ==========================================================
  // Read port
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        lrm_pkg::ctrl_off: rdata_q <= {30'h0, type_q, en_q};
        lrm_pkg::stat_off: rdata_q <= {31'h0, flag_q};
        lrm_pkg::thr_off: rdata_q <= {period_q, thr_q};
        lrm_pkg::cnt_off: rdata_q <= {window_elapsed_count, error_tally};
        lrm_pkg::irq_mask_off: rdata_q <= {31'h0, irq_mask_q};
        lrm_pkg::irq_stat_off: rdata_q <= {31'h0, irq_stat_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign reg_rdata = rdata_q;
endmodule : link_error_rate_monitor_counters

// ===== verif/lrm_props.sv
/* Port checker for the link reliability monitor.
   Assumes one core clock and a synchronous active-low reset. */
`timescale 1ns/100ps
module lrm_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Link and status
  input wire logic link_retrain_request,
  input wire logic ltssm_in_detect,
  input wire logic unreliable_link_flag
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic thr_wr_q;
  logic cnt_rd;
  logic no_clr;
  assign cnt_rd = reg_rd && reg_addr == lrm_pkg::cnt_off;
  assign no_clr = !link_retrain_request && !ltssm_in_detect;
  // ==========
  // Threshold still at its reset value until first written
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      thr_wr_q <= 1'b0;
    end else if (reg_wr && reg_addr == lrm_pkg::thr_off) begin
      thr_wr_q <= 1'b1;
    end
  end
  ret_clear_a: assert property ($past(link_retrain_request) && cnt_rd |=> reg_rdata == 32'h0)
    else $error("counts not cleared by retrain");
  det_clear_a: assert property ($past(ltssm_in_detect) && cnt_rd |=> reg_rdata == 32'h0)
    else $error("counts not cleared by detect");
  flag_hold_a: assert property (unreliable_link_flag && !reg_wr |=> unreliable_link_flag)
    else $error("flag dropped without a write");
  flag_clear_a: assert property ($fell(unreliable_link_flag) |-> $past(reg_wr) && $past(reg_addr) == lrm_pkg::stat_off)
    else $error("flag cleared without a status write");
  thr_reset_a: assert property (reg_rd && reg_addr == lrm_pkg::thr_off && !thr_wr_q |=> reg_rdata == 32'hffffffff)
    else $error("threshold reset value wrong");
  count_freeze_a: assert property (unreliable_link_flag && no_clr ##1 cnt_rd && unreliable_link_flag && no_clr
    ##1 cnt_rd && unreliable_link_flag && no_clr |=> reg_rdata == $past(reg_rdata))
    else $error("counts moved while frozen");
endmodule : lrm_props
bind link_error_rate_monitor_counters lrm_props u_props (.*);

// ===== verif/link_partner.sv
/* Link-side model: retrain, Detect and error event sources.
   Assumes the bench calls one task of it at a time. */
`timescale 1ns/100ps
module link_partner (
  // Clock
  input wire logic clk_sys,
  // Link events
  output logic retrain,
  output logic detect,
  output logic lcrc,
  output logic l0rec
);
  initial {retrain, detect, lcrc, l0rec} = 4'h0;
  // ==========
  // Single-cycle error events with an idle cycle between them; retrain or Detect held for n cycles
  task automatic errs(input logic kind, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      lcrc <= !kind;
      l0rec <= kind;
      @(posedge clk_sys);
      {lcrc, l0rec} <= 2'h0;
    end
  endtask : errs
  task automatic level(input logic det, input int n);
    @(posedge clk_sys);
    retrain <= !det;
    detect <= det;
    repeat (n) @(posedge clk_sys);
    {retrain, detect} <= 2'h0;
  endtask : level
endmodule : link_partner

// ===== verif/tb_top.sv
/* Self-checking bench for the link reliability monitor.
   Assumes the link partner model and the bound checker. */
`timescale 1ns/100ps
module tb_top;
  logic clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d, s;
  logic retrain, detect, lcrc, l0rec, flag, irq;
  int fails = 0, checks_done = 0;
  always #12.5 clk_sys = ~clk_sys;
  link_partner u_lk (.clk_sys(clk_sys), .retrain(retrain), .detect(detect), .lcrc(lcrc), .l0rec(l0rec));
  link_error_rate_monitor_counters u_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_retrain_request(retrain), .ltssm_in_detect(detect), .lcrc_error(lcrc),
    .l0_to_recovery_local(l0rec), .unreliable_link_flag(flag), .irq(irq));
  // ==========
  // Bus and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rc();
    rd(lrm_pkg::cnt_off);
  endtask : rc
  // Two count reads back to back, strobe held over two edges
  task automatic rc2(output logic [31:0] a0, output logic [31:0] a1);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= lrm_pkg::cnt_off;
    @(posedge clk_sys);
    #1 a0 = reg_rdata;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 a1 = reg_rdata;
  endtask : rc2
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  // Read taken while the clear request is still held
  task automatic clr_read(input logic det);
    fork
      u_lk.level(det, 4);
      begin
        idle(2);
        rc();
      end
    join
    chk(d, 32'h0);
  endtask : clr_read
  // ==========
  // Scenarios
  task automatic t_reset();
    rc();
    chk(d, 32'h0);
    rd(lrm_pkg::thr_off);
    chk(d, 32'hffffffff);
    rd(lrm_pkg::ctrl_off);
    chk(d, 32'h0);
    rd(12'h000);
    chk(d, 32'h0);
  endtask : t_reset
  task automatic t_count();
    u_lk.errs(0, 5);
    u_lk.errs(1, 3);
    rc();
    chk(d[7:0], 32'h5);
    wr(lrm_pkg::ctrl_off, 32'h2);
    u_lk.errs(1, 3);
    u_lk.errs(0, 2);
    rc();
    chk(d[7:0], 32'h8);
    clr_read(1'b0);
    u_lk.errs(0, 2);
    clr_read(1'b1);
    wr(lrm_pkg::ctrl_off, 32'h0);
    u_lk.errs(0, 260);
    rc();
    chk(d[7:0], 32'hff);
  endtask : t_count
  task automatic t_window();
    clr_read(1'b0);
    idle(400);
    rc();
    chk(d[31:8] >= 24'h9 && d[31:8] <= 24'hb, 32'h1);
    chk(d[31:8] >= 24'ha, 32'h1);
    wr(lrm_pkg::thr_off, {24'h3, 8'hc8});
    clr_read(1'b0);
    u_lk.errs(0, 2);
    idle(200);
    rc();
    chk(d[7:0], 32'h0);
    chk(d[31:8] <= 24'h3, 32'h1);
  endtask : t_window
  task automatic t_flag();
    wr(lrm_pkg::thr_off, 32'hffffff03);
    wr(lrm_pkg::irq_mask_off, 32'h1);
    clr_read(1'b0);
    u_lk.errs(0, 4);
    rc();
    chk(d[7:0], 32'h4);
    chk(flag, 32'h0);
    wr(lrm_pkg::ctrl_off, 32'h1);
    idle(3);
    rc();
    chk(d[7:0], 32'h0);
    chk(flag, 32'h0);
    u_lk.errs(0, 3);
    idle(2);
    chk({irq, flag}, 32'h3);
    rc();
    s = d;
    u_lk.errs(0, 2);
    rc();
    chk(d, s);
    rc2(s, d);
    chk(d, s);
    rd(lrm_pkg::irq_stat_off);
    chk(d[0], 32'h1);
    chk(irq, 32'h0);
    clr_read(1'b0);
    wr(lrm_pkg::ctrl_off, 32'h0);
    wr(lrm_pkg::stat_off, 32'h1);
    idle(2);
    chk(flag, 32'h0);
  endtask : t_flag
  task automatic final_report();
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_count();
    t_window();
    t_flag();
    final_report();
  end
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    final_report();
  end
endmodule : tb_top
